// ==== updown_timer_pkg.sv ====
`default_nettype none
package updown_timer_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_TIMERS = 3;
   localparam int AV_AW = 8;
   localparam int AV_DW = 32;
   localparam int AV_BEW = 4;

   // ------------------------------------------------------------
   // Address decode: byte address = timer * 0x20 + register * 4
   // ------------------------------------------------------------
   localparam int ADR_IDX_MSB = 6;
   localparam int ADR_IDX_LSB = 5;
   localparam int ADR_REG_MSB = 4;
   localparam int ADR_REG_LSB = 2;
   localparam int ADR_TOP_BIT = 7;
   localparam logic [1:0] ADR_ALIGN = 2'h0;
   localparam logic [1:0] LAST_TIMER = 2'h2;

   localparam logic [2:0] REG_CTL = 3'h0;
   localparam logic [2:0] REG_CFG = 3'h1;
   localparam logic [2:0] REG_CNT_LO = 3'h2;
   localparam logic [2:0] REG_CNT_HI = 3'h3;
   localparam logic [2:0] REG_CAP_LO = 3'h4;
   localparam logic [2:0] REG_CAP_HI = 3'h5;

   // ------------------------------------------------------------
   // Field positions of timer_control_reg and timer_config_reg
   // ------------------------------------------------------------
   localparam int CTL_TF_BIT = 7;
   localparam int CTL_EXF_BIT = 6;
   localparam int CTL_EXTEN_BIT = 3;
   localparam int CTL_RUN_BIT = 2;
   localparam int CTL_CSEL_BIT = 1;
   localparam int CTL_CPRL_BIT = 0;
   localparam int CFG_MODE_MSB = 4;
   localparam int CFG_MODE_LSB = 3;
   localparam int CFG_DECREMENT_ENABLE_BIT = 0;

   // ------------------------------------------------------------
   // Counting constants
   // ------------------------------------------------------------
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [3:0] DIV12_LAST = 4'hB;
   localparam logic [3:0] PRESC_ZERO = 4'h0;
   localparam logic [3:0] PRESC_ONE = 4'h1;
   localparam logic [2:0] OSC_DIV8_LAST = 3'h7;
   localparam logic [2:0] OSC_ONE = 3'h1;
   localparam logic [23:0] RD_PAD = 24'h000000;

   // Clock-mode codes of the two-bit field
   typedef enum logic [1:0] {
      CLK_SYS_DIV12 = 2'b00,
      CLK_SYS_DIV1  = 2'b01,
      CLK_OSC_DIV8  = 2'b10,
      CLK_SYS_DIV2  = 2'b11
   } clk_mode_e;

   // Avalon-MM request from the master
   typedef struct packed {
      logic [AV_AW-1:0] address;
      logic read;
      logic write;
      logic [AV_DW-1:0] writedata;
      logic [AV_BEW-1:0] byteenable;
   } avs_req_s;

   // Architectural state of one timer
   typedef struct packed {
      logic tf;
      logic exf;
      logic ext_en;
      logic run;
      logic csel;
      logic cprl;
      clk_mode_e mode;
      logic decrement_enable;
      logic [15:0] cnt;
      logic [15:0] cap;
   } timer_regs_s;

   localparam timer_regs_s TIMER_RESET = '{tf: 1'b0, exf: 1'b0, ext_en: 1'b0,
      run: 1'b0, csel: 1'b0, cprl: 1'b0, mode: CLK_SYS_DIV12, decrement_enable: 1'b0,
      cnt: 16'h0000, cap: 16'h0000};

endpackage
`default_nettype wire

// ==== updown_timer_capture_reload.sv ====
`default_nettype none
module updown_timer_capture_reload (
   input wire logic CLK,
   input wire logic RESETN,
   input wire updown_timer_pkg::avs_req_s AVS_REQ,
   output logic [updown_timer_pkg::AV_DW-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [updown_timer_pkg::NUM_TIMERS-1:0] COUNT_INPUT_PIN,
   input wire logic [updown_timer_pkg::NUM_TIMERS-1:0] TRIGGER_PIN,
   input wire logic OSC_CLK_PIN,
   output logic [updown_timer_pkg::NUM_TIMERS-1:0] OVF_PULSE,
   output logic [updown_timer_pkg::NUM_TIMERS-1:0] UART0_BAUD_TICK,
   output logic [1:0] UART1_BAUD_TICK,
   output logic [updown_timer_pkg::NUM_TIMERS-1:0] IRQ_REQ
);
   import updown_timer_pkg::*;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------

   // Timebase pulse for a clock-mode code
   // The default branch is never reached with a two-bit code
   function automatic logic base_tick(input clk_mode_e mode, input logic t12,
                                      input logic t2, input logic t8);
      logic t;
      t = 1'b0;
      case (mode)
         CLK_SYS_DIV12: t = t12;
         CLK_SYS_DIV1: t = 1'b1;
         CLK_OSC_DIV8: t = t8;
         CLK_SYS_DIV2: t = t2;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   // Register read view of one timer
   // Reserved bits read as zero
   function automatic logic [7:0] read_byte(input timer_regs_s r, input logic [2:0] sel);
      logic [7:0] b;
      b = 8'h00;
      case (sel)
         REG_CTL: begin
            b[CTL_TF_BIT] = r.tf;
            b[CTL_EXF_BIT] = r.exf;
            b[CTL_EXTEN_BIT] = r.ext_en;
            b[CTL_RUN_BIT] = r.run;
            b[CTL_CSEL_BIT] = r.csel;
            b[CTL_CPRL_BIT] = r.cprl;
         end
         REG_CFG: begin
            b[CFG_MODE_MSB:CFG_MODE_LSB] = r.mode;
            b[CFG_DECREMENT_ENABLE_BIT] = r.decrement_enable;
         end
         REG_CNT_LO: b = r.cnt[7:0];
         REG_CNT_HI: b = r.cnt[15:8];
         REG_CAP_LO: b = r.cap[7:0];
         REG_CAP_HI: b = r.cap[15:8];
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic rstn;

   // Release is synchronised so that no flop leaves reset a cycle apart
   // Assertion stays immediate, so outputs go quiet without a clock;
   // the price is two idle cycles before the first bus request
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rstn = rst_sync_ff[1];

   // ------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic [NUM_TIMERS-1:0] cnt_s1_ff;
   logic [NUM_TIMERS-1:0] cnt_s2_ff;
   logic [NUM_TIMERS-1:0] cnt_prev_ff;
   logic [NUM_TIMERS-1:0] trg_s1_ff;
   logic [NUM_TIMERS-1:0] trg_s2_ff;
   logic [NUM_TIMERS-1:0] trg_prev_ff;
   logic [1:0] osc_sync_ff;
   logic osc_prev_ff;
   logic [NUM_TIMERS-1:0] cnt_fall;
   logic [NUM_TIMERS-1:0] trg_fall;
   logic osc_rise;

   // Two flops before any logic; the third only holds the previous level
   // Flops reset low while idle pins sit high, so the first change after
   // reset is a rise, which the fall detectors ignore: no false count or trigger event
   // A level held for less than one clock may be missed altogether
   always_ff @(posedge CLK or negedge rstn) begin
      if (!rstn) begin
         cnt_s1_ff <= '0;
         cnt_s2_ff <= '0;
         cnt_prev_ff <= '0;
         trg_s1_ff <= '0;
         trg_s2_ff <= '0;
         trg_prev_ff <= '0;
         osc_sync_ff <= 2'b00;
         osc_prev_ff <= 1'b0;
      end else begin
         cnt_s1_ff <= COUNT_INPUT_PIN;
         cnt_s2_ff <= cnt_s1_ff;
         cnt_prev_ff <= cnt_s2_ff;
         trg_s1_ff <= TRIGGER_PIN;
         trg_s2_ff <= trg_s1_ff;
         trg_prev_ff <= trg_s2_ff;
         osc_sync_ff <= {osc_sync_ff[0], OSC_CLK_PIN};
         osc_prev_ff <= osc_sync_ff[1];
      end
   end

   // One pulse per detected edge
   // Edges are taken from the second flop, never the first
   assign cnt_fall = cnt_prev_ff & ~cnt_s2_ff;
   assign trg_fall = trg_prev_ff & ~trg_s2_ff;
   assign osc_rise = osc_sync_ff[1] & ~osc_prev_ff;

   // ------------------------------------------------------------
   // Shared prescalers
   // ------------------------------------------------------------
   logic div2_ff;
   logic [3:0] div12_ff;
   logic [2:0] osc8_ff;
   logic tick2;
   logic tick12;
   logic tick8;
   logic [3:0] nxt_div12;
   logic [2:0] nxt_osc8;

   // Oscillator is far slower than the system clock, so edge counting suffices
   // Dividers are shared and free-running: a timer started mid-period
   // sees its first tick up to one period late, traded for less logic
   assign tick2 = div2_ff;
   assign tick12 = (div12_ff == DIV12_LAST);
   assign tick8 = osc_rise & (osc8_ff == OSC_DIV8_LAST);
   assign nxt_div12 = tick12 ? PRESC_ZERO : div12_ff + PRESC_ONE;
   assign nxt_osc8 = osc_rise ? osc8_ff + OSC_ONE : osc8_ff;

   // Free-running dividers
   // Nothing resets them but the block reset
   always_ff @(posedge CLK or negedge rstn) begin
      if (!rstn) begin
         div2_ff <= 1'b0;
         div12_ff <= 4'h0;
         osc8_ff <= 3'h0;
      end else begin
         div2_ff <= ~div2_ff;
         div12_ff <= nxt_div12;
         osc8_ff <= nxt_osc8;
      end
   end

   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------
   logic ack_ff;
   logic [AV_DW-1:0] rdata_ff;
   logic req_any;
   logic req_go;
   logic wr_go;
   logic [1:0] hit_idx;
   logic [2:0] hit_reg;
   logic hit_ok;
   logic lane0;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   logic [AV_DW-1:0] nxt_rdata;
   timer_regs_s timer_ff [NUM_TIMERS];
   timer_regs_s nxt_timer [NUM_TIMERS];

   // One wait state: read data is latched first, writes land on the ack edge
   // Writes also wait one cycle so both directions time alike
   // A request seen with the ack high is the same one, not a new one
   assign req_any = AVS_REQ.read | AVS_REQ.write;
   assign req_go = req_any & ~ack_ff;
   assign wr_go = AVS_REQ.write & ack_ff;
   assign AVS_WAITREQUEST = req_any & ~ack_ff;

   // Address decode; unmapped reads give zero, unmapped writes vanish
   // Only byte lane 0 carries data; the upper lanes always read zero
   assign hit_idx = AVS_REQ.address[ADR_IDX_MSB:ADR_IDX_LSB];
   assign hit_reg = AVS_REQ.address[ADR_REG_MSB:ADR_REG_LSB];
   assign hit_ok = (AVS_REQ.address[1:0] == ADR_ALIGN) & ~AVS_REQ.address[ADR_TOP_BIT]
                   & (hit_idx <= LAST_TIMER) & (hit_reg <= REG_CAP_HI);
   assign lane0 = AVS_REQ.byteenable[0];
   assign wbyte = AVS_REQ.writedata[7:0];
   assign rd_byte = hit_ok ? read_byte(timer_ff[hit_idx], hit_reg) : 8'h00;
   assign nxt_rdata = (req_go & AVS_REQ.read) ? {RD_PAD, rd_byte} : rdata_ff;
   assign AVS_READDATA = rdata_ff;

   // Bus handshake state
   // Read data stand until the next read is taken; writes leave them
   always_ff @(posedge CLK or negedge rstn) begin
      if (!rstn) begin
         ack_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         ack_ff <= req_go;
         rdata_ff <= nxt_rdata;
      end
   end

   // ------------------------------------------------------------
   // Timer datapath, one copy per timer
   // ------------------------------------------------------------
   logic [NUM_TIMERS-1:0] nxt_ovf;
   logic [NUM_TIMERS-1:0] nxt_irq;
   logic [NUM_TIMERS-1:0] ovf_ff;
   logic [NUM_TIMERS-1:0] irq_ff;

   for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
      // Register view and write strobes
      timer_regs_s cur;
      logic sel;
      logic wr_ctl;
      logic wr_cfg;
      logic wr_clo;
      logic wr_chi;
      logic wr_plo;
      logic wr_phi;

      // Event decode
      logic evt;
      logic up;
      logic trig_act;
      logic capture;
      logic reload_trig;

      // Next-value terms
      logic wrap_hit;
      logic wrap;
      logic [15:0] cnt_step;
      logic [15:0] cnt_evt;
      logic [15:0] cnt_hw;
      logic [15:0] cap_sw;
      logic tf_base;
      logic exf_base;

      assign cur = timer_ff[i];
      assign sel = wr_go & hit_ok & lane0 & (hit_idx == 2'(i));
      assign wr_ctl = sel & (hit_reg == REG_CTL);
      assign wr_cfg = sel & (hit_reg == REG_CFG);
      assign wr_clo = sel & (hit_reg == REG_CNT_LO);
      assign wr_chi = sel & (hit_reg == REG_CNT_HI);
      assign wr_plo = sel & (hit_reg == REG_CAP_LO);
      assign wr_phi = sel & (hit_reg == REG_CAP_HI);

      // Count event: run gate, then pin edge or selected timebase
      // Clearing the run bit freezes the count but not the trigger logic
      assign evt = cur.run & (cur.csel ? cnt_fall[i]
                   : base_tick(cur.mode, tick12, tick2, tick8));
      // Without decrement enable the timer always counts up
      assign up = ~cur.decrement_enable | trg_s2_ff[i];
      // Trigger edges act only with external enable and no decrement enable
      assign trig_act = cur.ext_en & ~cur.decrement_enable & trg_fall[i];
      assign capture = trig_act & cur.cprl;
      assign reload_trig = trig_act & ~cur.cprl;

      // Wrap point: FFFF up; 0000 down in capture, reload value down otherwise
      // Counting down in reload mode, a count already below the reload
      // value has to run a full lap before it meets it again
      assign wrap_hit = up ? (cur.cnt == CNT_MAX)
                        : (cur.cprl ? (cur.cnt == CNT_ZERO) : (cur.cnt == cur.cap));
      // A trigger reload overrides a coincident count event
      assign wrap = evt & wrap_hit & ~reload_trig;
      assign cnt_step = up ? cur.cnt + CNT_ONE : cur.cnt - CNT_ONE;
      assign cnt_evt = (cur.cprl | ~wrap) ? cnt_step
                       : (up ? cur.cap : CNT_MAX);
      assign cnt_hw = reload_trig ? cur.cap : (evt ? cnt_evt : cur.cnt);

      // Software byte writes win over counting in the same cycle
      // Low and high bytes are independent: no latching between them
      assign nxt_timer[i].cnt[7:0] = wr_clo ? wbyte : cnt_hw[7:0];
      assign nxt_timer[i].cnt[15:8] = wr_chi ? wbyte : cnt_hw[15:8];

      // Hardware capture wins over a software write so no capture is lost
      assign cap_sw = {wr_phi ? wbyte : cur.cap[15:8], wr_plo ? wbyte : cur.cap[7:0]};
      assign nxt_timer[i].cap = capture ? cur.cnt : cap_sw;

      // Flags: set wins over clear; software clears them, and a wrap in reload mode toggles the external flag
      // In reload mode the toggle makes the external flag a seventeenth bit
      assign tf_base = wr_ctl ? wbyte[CTL_TF_BIT] : cur.tf;
      assign exf_base = wr_ctl ? wbyte[CTL_EXF_BIT] : cur.exf;
      assign nxt_timer[i].tf = tf_base | wrap;
      assign nxt_timer[i].exf = cur.cprl ? (exf_base | capture)
                                : (reload_trig | (exf_base ^ wrap));

      // Control and configuration fields
      // Reserved bits of a written byte are dropped
      assign nxt_timer[i].ext_en = wr_ctl ? wbyte[CTL_EXTEN_BIT] : cur.ext_en;
      assign nxt_timer[i].run = wr_ctl ? wbyte[CTL_RUN_BIT] : cur.run;
      assign nxt_timer[i].csel = wr_ctl ? wbyte[CTL_CSEL_BIT] : cur.csel;
      assign nxt_timer[i].cprl = wr_ctl ? wbyte[CTL_CPRL_BIT] : cur.cprl;
      assign nxt_timer[i].mode = wr_cfg ? clk_mode_e'(wbyte[CFG_MODE_MSB:CFG_MODE_LSB])
                                 : cur.mode;
      assign nxt_timer[i].decrement_enable = wr_cfg ? wbyte[CFG_DECREMENT_ENABLE_BIT] : cur.decrement_enable;

      // Outputs: wrap pulse and interrupt request level
      // The request is a raw level; enabling it is left to the controller
      assign nxt_ovf[i] = wrap;
      assign nxt_irq[i] = nxt_timer[i].tf | (nxt_timer[i].exf & nxt_timer[i].cprl);

      // Timer state
      // Each timer has its own process so the copies stay independent
      always_ff @(posedge CLK or negedge rstn) begin
         if (!rstn) begin
            timer_ff[i] <= TIMER_RESET;
         end else begin
            timer_ff[i] <= nxt_timer[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------

   // Registered pulse and request outputs
   // The pulse lands on the same edge as the count register's wrap update; consumers only count
   always_ff @(posedge CLK or negedge rstn) begin
      if (!rstn) begin
         ovf_ff <= '0;
         irq_ff <= '0;
      end else begin
         ovf_ff <= nxt_ovf;
         irq_ff <= nxt_irq;
      end
   end

   // Baud taps: every timer for the first UART, the first two for the second
   // The taps are plain copies, so every consumer sees the same pulse
   assign OVF_PULSE = ovf_ff;
   assign UART0_BAUD_TICK = ovf_ff;
   assign UART1_BAUD_TICK = ovf_ff[1:0];
   assign IRQ_REQ = irq_ff;

endmodule
`default_nettype wire

// ==== updown_timer_assertions.sv ====
`default_nettype none
// ---
// Port checker
// ---
module updown_timer_checker (
   input wire logic CLK,
   input wire logic RESETN,
   input wire updown_timer_pkg::avs_req_s AVS_REQ,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic [2:0] OVF_PULSE,
   input wire logic [2:0] UART0_BAUD_TICK,
   input wire logic [1:0] UART1_BAUD_TICK,
   input wire logic [2:0] IRQ_REQ
);
   import updown_timer_pkg::*;
   logic req_up;
   logic ctl0_wr;
   // Request present, and a write aimed at any timer's control register
   assign req_up = AVS_REQ.read | AVS_REQ.write;
   assign ctl0_wr = AVS_REQ.write && AVS_REQ.address[4:0] == 5'h00;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   a_wait_one_state: assert property (req_up && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("waitrequest held past one wait state");
   a_byte_wide_data: assert property (AVS_READDATA[31:8] == 24'h000000)
      else $error("read data above the byte lane not zero");
   a_rdata_only_read: assert property (!$stable(AVS_READDATA)
      |-> $past(AVS_REQ.read && AVS_WAITREQUEST))
      else $error("read data changed without a read");
   a_unmapped_reads_zero: assert property (AVS_REQ.read && !AVS_WAITREQUEST && AVS_REQ.address[7]
      |-> AVS_READDATA == 32'h00000000)
      else $error("unmapped read not zero");
   a_uart0_tick_copy: assert property (UART0_BAUD_TICK == OVF_PULSE)
      else $error("first uart tick differs from overflow");
   a_uart1_tick_copy: assert property (UART1_BAUD_TICK == OVF_PULSE[1:0])
      else $error("second uart tick differs from overflow");
   a_wrap_raises_irq: assert property ((OVF_PULSE & ~IRQ_REQ) == 3'h0)
      else $error("wrap without request");
   a_irq_needs_clear: assert property ((|($past(IRQ_REQ) & ~IRQ_REQ))
      |-> $past(ctl0_wr, 2))
      else $error("request dropped without software clear");
endmodule
bind updown_timer_capture_reload updown_timer_checker chk (.CLK(CLK), .RESETN(RESETN),
   .AVS_REQ(AVS_REQ), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .OVF_PULSE(OVF_PULSE), .UART0_BAUD_TICK(UART0_BAUD_TICK),
   .UART1_BAUD_TICK(UART1_BAUD_TICK), .IRQ_REQ(IRQ_REQ));
`default_nettype wire

// ==== updown_timer_pins.sv ====
`default_nettype none
// ---
// Pin and baud partner
// ---
module updown_timer_pins (
   input wire logic clk,
   input wire logic [2:0] baud_tick,
   output var logic [2:0] cnt_pin,
   output var logic [2:0] trg_pin,
   output var logic osc_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int ticks [3] = '{0, 0, 0};
   int oc = 0;
   // Pins idle high so that only deliberate falls count; trigger routed as input
   initial begin
      cnt_pin = 3'h7;
      trg_pin = 3'h7;
      osc_pin = 1'b0;
   end
   // Oscillator runs free, six cycles a period, unrelated to any test step
   always @(posedge clk) begin
      oc <= (oc == 2) ? 0 : oc + 1;
      if (oc == 2) osc_pin <= ~osc_pin;
   end
   // Baud consumer counts each tick it is offered
   always @(posedge clk) begin
      for (int i = 0; i < 3; i++) if (baud_tick[i] === 1'b1) ticks[i]++;
   end
   // Each level held three cycles, longer than the one the sampler needs
   task automatic pulse_cnt(input int t, input int n);
      repeat (n) begin
         cnt_pin[t] <= 1'b0;
         repeat (3) @(posedge clk);
         cnt_pin[t] <= 1'b1;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic fall_trg(input int t);
      trg_pin[t] <= 1'b0;
      repeat (3) @(posedge clk);
      trg_pin[t] <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic set_trg(input int t, input logic v);
      trg_pin[t] <= v;
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ==== updown_timer_capture_reload_tb.sv ====
`default_nettype none
module updown_timer_capture_reload_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import updown_timer_pkg::*;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   avs_req_s req = '0;
   logic [31:0] rdata;
   logic wait_req, osc;
   logic [2:0] cnt_pin, trg_pin, ovf, u0, irq;
   logic [1:0] u1;
   logic [7:0] q;
   logic [15:0] v, c;
   logic [7:0] bad_adr [4] = '{8'h80, 8'h60, 8'h18, 8'h01};
   int n_errors = 0, n_tests = 0, cyc = 0, t, k, n0;
   // ---
   // Clock, design, partner
   // ---
   always #2.5 CLK = ~CLK;
   updown_timer_capture_reload uut (.CLK(CLK), .RESETN(RESETN), .AVS_REQ(req),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .COUNT_INPUT_PIN(cnt_pin),
      .TRIGGER_PIN(trg_pin), .OSC_CLK_PIN(osc), .OVF_PULSE(ovf), .UART0_BAUD_TICK(u0),
      .UART1_BAUD_TICK(u1), .IRQ_REQ(irq));
   updown_timer_pins pins (.clk(CLK), .baud_tick(u0), .cnt_pin(cnt_pin), .trg_pin(trg_pin),
      .osc_pin(osc));
   // Hang guard, far above the few thousand cycles the tests need
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         print_verdict();
      end
   end
   // ---
   // Helpers
   // ---
   function automatic logic [7:0] adr(input int t, input logic [2:0] r);
      return 8'(t * 32) | {3'h0, r, 2'h0};
   endfunction
   // Counts expected after n cycles for each clock-mode code; osc/8 sees a six-cycle osc
   function automatic int exp_count(input int n, input int m);
      case (m)
         0: return n / 12;
         1: return n;
         2: return n / 48;
         default: return n / 2;
      endcase
   endfunction
   // Request held until the edge at which waitrequest is low
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      req.address <= a;
      req.read <= ~w;
      req.write <= w;
      req.writedata <= {24'h000000, d};
      req.byteenable <= 4'hF;
      // Waitrequest and read data are both taken at the rising edge
      do begin
         @(posedge CLK);
      end while (wait_req !== 1'b0);
      q = rdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic wr16(input int t, input logic [2:0] r, input logic [15:0] d);
      bus(adr(t, r), 1'b1, d[7:0]);
      bus(adr(t, r + 3'h1), 1'b1, d[15:8]);
   endtask
   task automatic rd16(input int t, input logic [2:0] r);
      bus(adr(t, r), 1'b0, 8'h00);
      v[7:0] = q;
      bus(adr(t, r + 3'h1), 1'b0, 8'h00);
      v[15:8] = q;
   endtask
   task automatic rdc(input int t);
      bus(adr(t, REG_CTL), 1'b0, 8'h00);
   endtask
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic near(input string what, input int e, input logic [15:0] g);
      n_tests++;
      if ($isunknown(g) || int'(g) > e + 3 || int'(g) + 3 < e) begin
         n_errors++;
         $display("wrong value %s expected %0d seen %0d", what, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("counts: %0d checks, %0d mismatches", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ---
   // Main sequence
   // ---
   initial begin
      void'($urandom(32'hB7E9));
      repeat (4) @(posedge CLK);
      RESETN <= 1'b1;
      repeat (3) @(posedge CLK);
      for (k = 0; k < 18; k++) begin
         bus(adr(k / 6, 3'(k % 6)), 1'b0, 8'h00);
         chk("reset value", 16'h0000, {8'h00, q});
      end
      foreach (bad_adr[i]) begin
         wr(bad_adr[i], 8'h5A);
         bus(bad_adr[i], 1'b0, 8'h00);
         chk("unmapped", 16'h0000, {8'h00, q});
      end
      $display("test map done");
      // Each timer keeps its own bytes
      for (t = 0; t < 3; t++) wr16(t, REG_CNT_LO, 16'(32'h1111 * (t + 1)));
      for (t = 0; t < 3; t++) begin
         c = 16'($urandom);
         wr16(t, REG_CAP_LO, c);
         rd16(t, REG_CAP_LO);
         chk("capture bytes", c, v);
         rd16(t, REG_CNT_LO);
         chk("count bytes", 16'(32'h1111 * (t + 1)), v);
      end
      $display("test bytes done");
      for (k = 0; k < 4; k++) begin
         t = $urandom_range(2, 0);
         wr(adr(t, REG_CFG), 8'(k << 3));
         wr16(t, REG_CNT_LO, 16'h0000);
         wr(adr(t, REG_CTL), 8'h04);
         repeat (480) @(posedge CLK);
         wr(adr(t, REG_CTL), 8'h00);
         rd16(t, REG_CNT_LO);
         near("timebase", exp_count(483, k), v);
      end
      $display("test timebase done");
      // Counter function, up then down with the trigger steering
      t = $urandom_range(2, 0);
      k = $urandom_range(9, 3);
      wr(adr(t, REG_CFG), 8'h00);
      wr16(t, REG_CNT_LO, 16'h0000);
      wr16(t, REG_CAP_LO, 16'h5A5A);
      wr(adr(t, REG_CTL), 8'h07);
      pins.pulse_cnt(t, k);
      rd16(t, REG_CNT_LO);
      chk("count up", 16'(k), v);
      wr(adr(t, REG_CFG), 8'h01);
      wr16(t, REG_CNT_LO, 16'h0000);
      pins.set_trg(t, 1'b0);
      wr(adr(t, REG_CTL), 8'h0F);
      pins.pulse_cnt(t, k);
      rd16(t, REG_CNT_LO);
      chk("count down", 16'(-k), v);
      rdc(t);
      chk("down flags", 16'h008F, {8'h00, q});
      rd16(t, REG_CAP_LO);
      chk("no capture", 16'h5A5A, v);
      pins.set_trg(t, 1'b1);
      $display("test counter done");
      // Capture gated by external enable
      wr(adr(t, REG_CFG), 8'h00);
      wr(adr(t, REG_CTL), 8'h07);
      c = 16'($urandom);
      wr16(t, REG_CNT_LO, c);
      pins.fall_trg(t);
      rd16(t, REG_CAP_LO);
      chk("ignored trigger", 16'h5A5A, v);
      wr(adr(t, REG_CTL), 8'h0F);
      pins.fall_trg(t);
      rd16(t, REG_CAP_LO);
      chk("captured", c, v);
      repeat (20) @(posedge CLK);
      rdc(t);
      chk("capture flag", 16'h004F, {8'h00, q});
      chk("capture request", 16'h0001, {15'h0000, irq[t]});
      wr(adr(t, REG_CTL), 8'h0F);
      rdc(t);
      chk("flag cleared", 16'h000F, {8'h00, q});
      chk("request cleared", 16'h0000, {15'h0000, irq[t]});
      $display("test capture done");
      // Reload on overflow, flag toggles, one baud tick per wrap
      wr(adr(t, REG_CTL), 8'h06);
      wr16(t, REG_CAP_LO, 16'h1000);
      wr16(t, REG_CNT_LO, 16'hFFFE);
      n0 = pins.ticks[t];
      pins.pulse_cnt(t, 2);
      rd16(t, REG_CNT_LO);
      chk("reloaded", 16'h1000, v);
      rdc(t);
      chk("wrap flags", 16'h00C6, {8'h00, q});
      chk("baud ticks", 16'h0001, 16'(pins.ticks[t] - n0));
      wr16(t, REG_CNT_LO, 16'hFFFF);
      pins.pulse_cnt(t, 1);
      rdc(t);
      chk("toggle back", 16'h0086, {8'h00, q});
      // Trigger reload
      wr(adr(t, REG_CTL), 8'h0E);
      c = 16'($urandom);
      wr16(t, REG_CAP_LO, c);
      wr16(t, REG_CNT_LO, 16'h0005);
      pins.fall_trg(t);
      rd16(t, REG_CNT_LO);
      chk("trigger reload", c, v);
      rdc(t);
      chk("trigger flag", 16'h004E, {8'h00, q});
      // Down count meets the reload value
      wr(adr(t, REG_CTL), 8'h06);
      wr(adr(t, REG_CFG), 8'h01);
      pins.set_trg(t, 1'b0);
      wr16(t, REG_CAP_LO, 16'h0010);
      wr16(t, REG_CNT_LO, 16'h0013);
      pins.pulse_cnt(t, 4);
      rd16(t, REG_CNT_LO);
      chk("underflow load", 16'hFFFF, v);
      rdc(t);
      chk("underflow flags", 16'h00C6, {8'h00, q});
      $display("test reload done");
      print_verdict();
   end
endmodule
`default_nettype wire
